//--- design/port_cd_pkg.sv
/*
  Constants shared by the port B/C/D data-register block.
  Assumes a 16-bit register port with byte enables on a plain strobe bus.
*/
package port_cd_pkg;
  localparam logic [31:0] PORT_B_ADDR = 32'hFFFF8386;
  localparam logic [31:0] PORT_C_ADDR = 32'hFFFF8390;
  localparam logic [31:0] PORT_D_ADDR = 32'hFFFF8398;
  localparam logic [15:0] PORT_B_RESET = 16'hC0C0;
  localparam logic [15:0] PORT_C_RESET = 16'h8000;
  localparam logic [15:0] PORT_D_RESET = 16'h0000;
  // Writable bits of each register
  localparam logic [15:0] PORT_B_WMASK = 16'h3F3F;
  localparam logic [15:0] PORT_C_WMASK = 16'h7FFF;
  localparam logic [15:0] PORT_D_WMASK = 16'hFFFF;
  // Port B bits that obey the output-disable input; stored here but never driven by this block
  localparam logic [15:0] PORT_B_POD_BITS = 16'h1F00;
  localparam int ACCESS_CYCLES = 2;
  // Operating modes for port D pin sharing
  typedef enum logic [3:0] {
    MODE_SINGLE = 4'h1,
    MODE_ROM_ON = 4'h2,
    MODE_ROM_OFF_8 = 4'h4,
    MODE_ROM_OFF_16 = 4'h8
  } bus_mode_e;
  // Pin function selects
  localparam logic [1:0] FN_GENERAL = 2'h0;
  localparam logic [1:0] FN_OTHER = 2'h1;
endpackage

//--- design/port_cd_regs.sv
/*
  Port B, C and D data registers with pin muxing; port B bits 8..12 are never driven.
  Assumes directions, function selects and bus mode come from elsewhere
  as steady levels, and byte lanes are given per access.
*/
`timescale 1ns/1ns
`default_nettype none
module port_cd_regs (
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic HW_STANDBY_I,
  input wire logic WDT_RESET_I,
  input wire logic [31:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic [1:0] BYTE_EN_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  output logic BUSY_O,
  input wire logic [15:0] PB_DIR_I,
  input wire logic [15:0] PB_GENERAL_I,
  input wire logic [15:0] PB_PIN_I,
  output logic [15:0] PB_PIN_O,
  output logic [15:0] PB_PIN_OE_O,
  input wire logic [15:0] PC_DIR_I,
  input wire logic [15:0] PC_GENERAL_I,
  input wire logic [15:0] PC_PIN_I,
  output logic [15:0] PC_PIN_O,
  output logic [15:0] PC_PIN_OE_O,
  input wire logic [15:0] PD_DIR_I,
  input wire logic [15:0] PD_GENERAL_I,
  input wire logic [15:0] PD_PIN_I,
  input wire logic [3:0] BUS_MODE_I,
  input wire logic OUTPUT_DISABLE_N_I,
  output logic [15:0] PD_PIN_O,
  output logic [15:0] PD_PIN_OE_O,
  output logic [15:0] PD_DATA_BUS_SEL_O
);
  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [15:0] port_b_pin_data_reg;
  logic [15:0] port_c_pin_data_reg;
  logic [15:0] port_d_pin_data_reg;
  logic [15:0] pd_general_eff;
  logic [15:0] pb_read;
  logic [15:0] pc_read;
  logic [15:0] pd_read;
  logic [15:0] pb_drive_en;
  logic [15:0] pc_drive_en;
  logic [15:0] pd_drive_en;
  logic [15:0] pb_drive_val;
  logic [15:0] pc_drive_val;
  logic [15:0] pd_drive_val;
  logic busy_reg;
  logic wr_ok;
  logic soft_reset;

  // Merge written byte lanes under a writable mask
  function automatic logic [15:0] merge_write(input logic [15:0] old, input logic [15:0] wd,
                                               input logic [1:0] be, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge_write = (old & ~lanes) | (wd & lanes);
  endfunction

  // Watchdog power-on reset leaves data alone; standby reinitialises
  assign soft_reset = HW_STANDBY_I & ~WDT_RESET_I;
  // Sleep and software standby are not inputs: contents simply persist
  // Master never waits, so a strobe right after another is still taken
  assign wr_ok = WR_I;

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      port_b_pin_data_reg <= port_cd_pkg::PORT_B_RESET;
    end else if (soft_reset) begin
      port_b_pin_data_reg <= port_cd_pkg::PORT_B_RESET;
    end else if (wr_ok && ADDR_I == port_cd_pkg::PORT_B_ADDR) begin
      port_b_pin_data_reg <= merge_write(port_b_pin_data_reg, WDATA_I, BYTE_EN_I,
                                         port_cd_pkg::PORT_B_WMASK);
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      port_c_pin_data_reg <= port_cd_pkg::PORT_C_RESET;
    end else if (soft_reset) begin
      port_c_pin_data_reg <= port_cd_pkg::PORT_C_RESET;
    end else if (wr_ok && ADDR_I == port_cd_pkg::PORT_C_ADDR) begin
      // Bit 15 is outside the mask and stays one
      port_c_pin_data_reg <= merge_write(port_c_pin_data_reg, WDATA_I, BYTE_EN_I,
                                         port_cd_pkg::PORT_C_WMASK);
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      port_d_pin_data_reg <= port_cd_pkg::PORT_D_RESET;
    end else if (soft_reset) begin
      port_d_pin_data_reg <= port_cd_pkg::PORT_D_RESET;
    end else if (wr_ok && ADDR_I == port_cd_pkg::PORT_D_ADDR) begin
      port_d_pin_data_reg <= merge_write(port_d_pin_data_reg, WDATA_I, BYTE_EN_I,
                                         port_cd_pkg::PORT_D_WMASK);
    end
  end

  // ==========================================================================
  // Two-cycle access timing
  // ==========================================================================
  // Flags the second cycle of each access; a new strobe may overlap it
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= WR_I | RD_I;
    end
  end

  assign BUSY_O = busy_reg;

  // ==========================================================================
  // Port D pin sharing by mode
  // ==========================================================================
  always_comb begin
    PD_DATA_BUS_SEL_O = 16'h0000;
    pd_general_eff = PD_GENERAL_I;
    case (BUS_MODE_I)
      port_cd_pkg::MODE_SINGLE: begin
        pd_general_eff = 16'hFFFF;
      end
      port_cd_pkg::MODE_ROM_ON: begin
        PD_DATA_BUS_SEL_O = ~PD_GENERAL_I;
      end
      port_cd_pkg::MODE_ROM_OFF_8: begin
        PD_DATA_BUS_SEL_O = {~PD_GENERAL_I[15:8], 8'hFF};
        pd_general_eff = {PD_GENERAL_I[15:8], 8'h00};
      end
      port_cd_pkg::MODE_ROM_OFF_16: begin
        PD_DATA_BUS_SEL_O = 16'hFFFF;
        pd_general_eff = 16'h0000;
      end
      default: begin
        pd_general_eff = PD_GENERAL_I;
      end
    endcase
  end

  // ==========================================================================
  // Pin slices
  // ==========================================================================
  port_pin_if #(.W(16)) pb_if ();
  port_pin_if #(.W(16)) pc_if ();
  port_pin_if #(.W(16)) pd_if ();

  assign pb_if.data = port_b_pin_data_reg;
  assign pb_if.dir = PB_DIR_I;
  assign pb_if.general = PB_GENERAL_I & ~port_cd_pkg::PORT_B_POD_BITS;
  assign pb_if.pin_in = PB_PIN_I;
  assign pb_if.hold_off = 1'b0;
  assign pb_read = pb_if.read_val;
  assign pb_drive_en = pb_if.drive_en;
  assign pb_drive_val = pb_if.drive_val;

  assign pc_if.data = port_c_pin_data_reg;
  assign pc_if.dir = PC_DIR_I & port_cd_pkg::PORT_C_WMASK;
  assign pc_if.general = PC_GENERAL_I & port_cd_pkg::PORT_C_WMASK;
  assign pc_if.pin_in = PC_PIN_I;
  assign pc_if.hold_off = 1'b0;
  assign pc_read = pc_if.read_val;
  assign pc_drive_en = pc_if.drive_en;
  assign pc_drive_val = pc_if.drive_val;

  assign pd_if.data = port_d_pin_data_reg;
  assign pd_if.dir = PD_DIR_I;
  assign pd_if.general = pd_general_eff;
  assign pd_if.pin_in = PD_PIN_I;
  assign pd_if.hold_off = ~OUTPUT_DISABLE_N_I;
  assign pd_read = pd_if.read_val;
  assign pd_drive_en = pd_if.drive_en;
  assign pd_drive_val = pd_if.drive_val;

  port_pin_slice #(.W(16)) u_pb (.p(pb_if));
  port_pin_slice #(.W(16)) u_pc (.p(pc_if));
  port_pin_slice #(.W(16)) u_pd (.p(pd_if));

  assign PB_PIN_O = pb_drive_val;
  assign PB_PIN_OE_O = pb_drive_en;
  assign PC_PIN_O = pc_drive_val;
  assign PC_PIN_OE_O = pc_drive_en;
  assign PD_PIN_O = pd_drive_val;
  assign PD_PIN_OE_O = pd_drive_en;

  // ==========================================================================
  // Read data, one cycle after the strobe
  // ==========================================================================
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      RDATA_O <= 16'h0000;
    end else if (RD_I) begin
      case (ADDR_I)
        port_cd_pkg::PORT_B_ADDR: RDATA_O <= (pb_read & port_cd_pkg::PORT_B_WMASK)
                                             | (port_cd_pkg::PORT_B_RESET & ~port_cd_pkg::PORT_B_WMASK);
        port_cd_pkg::PORT_C_ADDR: RDATA_O <= {1'b1, pc_read[14:0]};
        port_cd_pkg::PORT_D_ADDR: RDATA_O <= pd_read;
        default: RDATA_O <= 16'h0000;
      endcase
    end else begin
      RDATA_O <= 16'h0000;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);

  a_pc_top_bit: assert property (port_c_pin_data_reg[15] == 1'b1)
    else $error("port C bit 15 not one");
  a_pc_out_drive: assert property (PC_DIR_I[3] && PC_GENERAL_I[3] |-> PC_PIN_OE_O[3])
    else $error("port C general output not driven");
  a_pc_in_read: assert property (RD_I && !busy_reg && ADDR_I == port_cd_pkg::PORT_C_ADDR && !PC_DIR_I[0]
                                 |=> RDATA_O[0] == $past(PC_PIN_I[0]))
    else $error("port C input read wrong");
  a_pc_other_nodrive: assert property (!PC_GENERAL_I[5] |-> !PC_PIN_OE_O[5])
    else $error("port C non-general pin driven");
  a_pd_disable: assert property (!OUTPUT_DISABLE_N_I |-> PD_PIN_OE_O == 16'h0000)
    else $error("port D drives while disabled");
  a_pd_bus16: assert property (BUS_MODE_I == port_cd_pkg::MODE_ROM_OFF_16
                               |-> PD_DATA_BUS_SEL_O == 16'hFFFF && PD_PIN_OE_O == 16'h0000)
    else $error("port D not all bus in 16-bit mode");
  a_pd_bus8: assert property (BUS_MODE_I == port_cd_pkg::MODE_ROM_OFF_8
                              |-> PD_DATA_BUS_SEL_O[7:0] == 8'hFF)
    else $error("port D low byte not bus");
  a_pd_single: assert property (BUS_MODE_I == port_cd_pkg::MODE_SINGLE
                                |-> PD_DATA_BUS_SEL_O == 16'h0000)
    else $error("port D bus in single-chip");
  a_two_cycle: assert property ((WR_I || RD_I) |=> busy_reg ##1 (busy_reg == $past(WR_I || RD_I)))
    else $error("access not two cycles");
  a_pd_write: assert property (WR_I && !busy_reg && ADDR_I == port_cd_pkg::PORT_D_ADDR && BYTE_EN_I == 2'h3
                               && !soft_reset |=> port_d_pin_data_reg == $past(WDATA_I))
    else $error("port D write lost");
  a_pc_standby: assert property (soft_reset |=> port_c_pin_data_reg == port_cd_pkg::PORT_C_RESET)
    else $error("port C not reset in standby");

  c_pc_write: cover property (wr_ok && ADDR_I == port_cd_pkg::PORT_C_ADDR);
  c_pd_read: cover property (RD_I && !busy_reg && ADDR_I == port_cd_pkg::PORT_D_ADDR);
  c_pd_disabled: cover property (!OUTPUT_DISABLE_N_I && PD_DIR_I != 16'h0000);
endmodule // port_cd_regs
`default_nettype wire

//--- design/port_pin_if.sv
/*
  Interface carrying one port's register value, direction and pin levels
  between the register block and a pin-mux slice.
*/
`timescale 1ns/1ns
`default_nettype none
interface port_pin_if #(parameter int W = 16);
  logic [W-1:0] data;
  logic [W-1:0] dir;
  logic [W-1:0] general;
  logic [W-1:0] pin_in;
  logic [W-1:0] read_val;
  logic [W-1:0] drive_val;
  logic [W-1:0] drive_en;
  logic hold_off;
  modport regs (output data, dir, general, hold_off, input read_val, drive_val, drive_en, pin_in);
  modport pins (input data, dir, general, hold_off, pin_in, output read_val, drive_val, drive_en);
endinterface
`default_nettype wire

//--- design/port_pin_slice.sv
/*
  Per-pin read mux and output driver for one port.
  Assumes pin inputs are synchronous to the clock.
*/
`timescale 1ns/1ns
`default_nettype none
module port_pin_slice #(
  parameter int W = 16
) (
  port_pin_if.pins p
);
  // Direction 0 reads the pin; direction 1 reads the stored bit
  assign p.read_val = (p.dir & p.data) | (~p.dir & p.pin_in);
  assign p.drive_val = p.data;
  // Only general outputs drive; a held-off port floats
  assign p.drive_en = (p.dir & p.general) & {W{~p.hold_off}};
endmodule // port_pin_slice
`default_nettype wire

//--- verification/pin_board.sv
/*
  Board-side model of one port's pins: a pin shows the device drive while
  enabled, else the level that outside circuitry puts on it.
  Assumes no pull resistors; the bench chooses the outside level.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_board (
  input wire logic [15:0] drive_i,
  input wire logic [15:0] oe_i,
  input wire logic [15:0] outside_i,
  output logic [15:0] level_o
);
  // ==========================================
  // Pin resolution
  // Undriven pins follow the outside level, never a stale drive
  always_comb begin
    level_o = (drive_i & oe_i) | (outside_i & ~oe_i);
  end
endmodule // pin_board
`default_nettype wire

//--- verification/testbench.sv
/*
  Self-checking bench for the port B/C/D data registers.
  Assumes the register bus and pin boards are the only surroundings.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0, nrst = 1'b0, stby = 1'b0, wdt = 1'b0, wr = 1'b0, rd = 1'b0, odn = 1'b1;
  logic [31:0] addr = 32'h0;
  logic [15:0] wdata = 16'h0, b_dir = '1, b_gen = '0, c_dir = 16'h7FFF, c_gen = '0, d_dir = '1, d_gen = '0;
  logic [15:0] b_ext = '0, c_ext = '0, d_ext = '0;
  logic [1:0] be = 2'h3;
  logic [3:0] mode = 4'h1;
  logic [15:0] rdata, b_out, b_oe, c_out, c_oe, d_out, d_oe, d_sel, b_lvl, c_lvl, d_lvl;
  logic busy;
  int error_cnt = 0, check_count = 0, cycles = 0;
  localparam logic [31:0] AB = 32'hFFFF8386, AC = 32'hFFFF8390, AD = 32'hFFFF8398;
  always #25 clk = ~clk;
  port_cd_regs u_port_cd_regs (.CLOCK_I(clk), .NRST_I(nrst), .HW_STANDBY_I(stby), .WDT_RESET_I(wdt),
    .ADDR_I(addr), .WDATA_I(wdata), .BYTE_EN_I(be), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .BUSY_O(busy),
    .PB_DIR_I(b_dir), .PB_GENERAL_I(b_gen), .PB_PIN_I(b_lvl), .PB_PIN_O(b_out), .PB_PIN_OE_O(b_oe),
    .PC_DIR_I(c_dir), .PC_GENERAL_I(c_gen), .PC_PIN_I(c_lvl), .PC_PIN_O(c_out), .PC_PIN_OE_O(c_oe),
    .PD_DIR_I(d_dir), .PD_GENERAL_I(d_gen), .PD_PIN_I(d_lvl), .BUS_MODE_I(mode),
    .OUTPUT_DISABLE_N_I(odn), .PD_PIN_O(d_out), .PD_PIN_OE_O(d_oe), .PD_DATA_BUS_SEL_O(d_sel));
  pin_board u_board_b (.drive_i(b_out), .oe_i(b_oe), .outside_i(b_ext), .level_o(b_lvl));
  pin_board u_board_c (.drive_i(c_out), .oe_i(c_oe), .outside_i(c_ext), .level_o(c_lvl));
  pin_board u_board_d (.drive_i(d_out), .oe_i(d_oe), .outside_i(d_ext), .level_o(d_lvl));
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [31:0] a, input logic [15:0] d, input logic [1:0] lanes);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= lanes;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1 chk({15'h0, busy}, 16'h0001, "busy after write");
  endtask
  task automatic rd_reg(input logic [31:0] a, input logic [15:0] exp, input logic [15:0] m);
    @(posedge clk);
    addr <= a;
    be <= 2'h3;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata & m, exp & m, "read data");
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset_and_c_out();
    rd_reg(AC, 16'h8000, '1);
    rd_reg(AD, 16'h0000, '1);
    rd_reg(AB, 16'hC0C0, '1);
    @(posedge clk) c_gen <= '1;
    wr_reg(AC, 16'h2A55, 2'h3);
    chk(c_oe, 16'h7FFF, "pc oe");
    chk(c_lvl & 16'h7FFF, 16'h2A55, "pc pins");
    rd_reg(AC, 16'hAA55, '1);
    wr_reg(AC, 16'h0000, 2'h3);
    rd_reg(AC, 16'h8000, '1);
  endtask
  task automatic t_c_input_other();
    @(posedge clk) c_dir <= '0;
    c_ext <= 16'h1234;
    rd_reg(AC, 16'h9234, '1);
    wr_reg(AC, 16'h0F0F, 2'h3);
    chk(c_oe, 16'h0000, "pc in oe");
    @(posedge clk) c_gen <= '0;
    c_dir <= 16'h7FFF;
    rd_reg(AC, 16'h8F0F, '1);
    wr_reg(AC, 16'h7000, 2'h3);
    chk(c_oe, 16'h0000, "pc other oe");
    rd_reg(AC, 16'hF000, '1);
    @(posedge clk) c_dir <= '0;
    rd_reg(AC, 16'h9234, '1);
  endtask
  task automatic t_byte_lanes();
    @(posedge clk) c_dir <= 16'h7FFF;
    wr_reg(AC, 16'h1111, 2'h3);
    wr_reg(AC, 16'hABCD, 2'h2);
    rd_reg(AC, 16'hAB11, '1);
    wr_reg(AC, 16'h55EE, 2'h1);
    rd_reg(AC, 16'hABEE, '1);
  endtask
  task automatic t_back_to_back();
    @(posedge clk) c_dir <= 16'h7FFF;
    addr <= AC;
    wdata <= 16'h0A0A;
    be <= 2'h3;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata, 16'h8A0A, "back to back read");
    chk({15'h0, busy}, 16'h0001, "busy after back to back");
  endtask
  task automatic t_port_d();
    @(posedge clk) d_gen <= '1;
    d_ext <= 16'h3C3C;
    wr_reg(AD, 16'hA5C3, 2'h3);
    chk(d_lvl, 16'hA5C3, "pd pins");
    chk(d_sel, 16'h0000, "pd single chip");
    @(posedge clk) odn <= 1'b0;
    #1 chk(d_oe, 16'h0000, "pd disabled");
    rd_reg(AD, 16'hA5C3, '1);
    @(posedge clk) d_dir <= '0;
    rd_reg(AD, 16'h3C3C, '1);
    wr_reg(AD, 16'h0000, 2'h1);
    @(posedge clk) d_dir <= '1;
    odn <= 1'b1;
    #1 chk(d_lvl, 16'hA500, "pd enabled");
  endtask
  task automatic t_bus_modes();
    logic [3:0] m [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
    logic [15:0] s [4] = '{16'h0000, 16'hF0F0, 16'hF0FF, 16'hFFFF};
    @(posedge clk) d_gen <= 16'h0F0F;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) mode <= m[i];
      #1 chk(d_sel, s[i], "pd bus select");
    end
    @(posedge clk) mode <= 4'h1;
  endtask
  task automatic t_port_b();
    @(posedge clk) b_gen <= '1;
    odn <= 1'b0;
    wr_reg(AB, 16'h002A, 2'h3);
    chk(b_oe & 16'h203F, 16'h203F, "pb oe");
    chk(b_lvl & 16'h003F, 16'h002A, "pb pins");
    @(posedge clk) b_dir <= '0;
    b_ext <= 16'h0015;
    odn <= 1'b1;
    rd_reg(AB, 16'h0015, 16'h003F);
    wr_reg(AB, 16'h003F, 2'h3);
    chk(b_lvl & 16'h003F, 16'h0015, "pb in pins");
    @(posedge clk) b_dir <= '1;
    rd_reg(AB, 16'h003F, 16'h003F);
  endtask
  task automatic t_standby();
    @(posedge clk) d_gen <= '0;
    c_gen <= '0;
    wr_reg(AC, 16'h1234, 2'h3);
    wr_reg(AD, 16'h5678, 2'h3);
    @(posedge clk) stby <= 1'b1;
    wdt <= 1'b1;
    repeat (3) @(posedge clk);
    stby <= 1'b0;
    wdt <= 1'b0;
    rd_reg(AC, 16'h9234, '1);
    rd_reg(AD, 16'h5678, '1);
    @(posedge clk) stby <= 1'b1;
    repeat (2) @(posedge clk);
    stby <= 1'b0;
    rd_reg(AC, 16'h8000, '1);
    rd_reg(AD, 16'h0000, '1);
    wr_reg(AC, 16'h1234, 2'h3);
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(AC, 16'h8000, '1);
  endtask
  // ==========================================
  // Main sequence and hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_reset_and_c_out();
    t_c_input_other();
    t_byte_lanes();
    t_back_to_back();
    t_port_d();
    t_bus_modes();
    t_port_b();
    t_standby();
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
